//--- motor_cfg_pkg.sv
// Register map, field layout and constants of the motor configuration block.
package motor_cfg_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [3:0] CFG_B_ADDR = 4'h0;
    localparam logic [3:0] IRQ_STAT_ADDR = 4'h4;
    localparam logic [3:0] IRQ_MASK_ADDR = 4'h8;
    localparam logic [3:0] CTRL_ADDR = 4'hC;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_B_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ------------------------------------------------------------
    // Field positions of motor_config_b
    // ------------------------------------------------------------
    localparam int VR_LSB = 6;
    localparam int POL_BIT = 5;
    localparam int HW_BIT = 4;
    localparam int SW_BIT = 3;
    localparam int PRE_BIT = 2;
    localparam int POST_LSB = 0;

    // ------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------
    localparam int SENSOR_BIT = 0;
    localparam int DIRECT_BIT = 1;
    localparam int SWDM_BIT = 2;
    localparam int PRE_ACT_BIT = 3;
    localparam int PHASE_BIT = 4;

    // ------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_COMM = 0;
    localparam int IRQ_DEMAG = 1;
    localparam int IRQ_ZC = 2;

    // ------------------------------------------------------------
    // Reference thresholds in millivolts: 200, 600, 1200, 2500
    // ------------------------------------------------------------
    localparam logic [11:0] VREF_MV_0 = 12'h0C8;
    localparam logic [11:0] VREF_MV_1 = 12'h258;
    localparam logic [11:0] VREF_MV_2 = 12'h4B0;
    localparam logic [11:0] VREF_MV_3 = 12'h9C4;

    typedef enum logic {PH_PRE, PH_POST} phase_type;

endpackage

//--- motor_cfg_if.sv
// Configuration and event signals between the register block and the phase core.
`timescale 1ns/1ps
interface motor_cfg_if;
    logic [1:0] vref;
    logic zc_pol;
    logic hw_en;
    logic sw_en;
    logic pre_mode_load;
    logic sensor;
    logic direct;
    logic sw_demag_req;
    logic zc_evt;
    logic demag_end_evt;
    logic before_demag;
    logic pre_mode_active;

    modport ctrl (
        output vref, zc_pol, hw_en, sw_en, pre_mode_load, sensor, direct, sw_demag_req,
        input zc_evt, demag_end_evt, before_demag, pre_mode_active
    );
    modport core (
        input vref, zc_pol, hw_en, sw_en, pre_mode_load, sensor, direct, sw_demag_req,
        output zc_evt, demag_end_evt, before_demag, pre_mode_active
    );
endinterface

//--- irq_sticky.sv
// Sticky interrupt status with write-one-to-clear, mask and level output.
`timescale 1ns/1ps
module irq_sticky
    import motor_cfg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Events and software access
    input wire logic [IRQ_W-1:0] evt,
    input wire logic clr_we,
    input wire logic mask_we,
    input wire logic [IRQ_W-1:0] wdata,
    input wire logic [IRQ_W-1:0] gate,
    // State and request
    output logic [IRQ_W-1:0] status_r,
    output logic [IRQ_W-1:0] mask_r,
    output logic irq_r
);

    // ------------------------------------------------------------
    // Per-bit status flags
    // ------------------------------------------------------------
    for (genvar i = 0; i < IRQ_W; i++) begin : g_bit
        // A new event in the clear cycle keeps the flag set.
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                status_r[i] <= 1'h0;
            end else if (evt[i]) begin
                status_r[i] <= 1'h1;
            end else if (clr_we && wdata[i]) begin
                status_r[i] <= 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= IRQ_RESET;
        end else if (mask_we) begin
            mask_r <= wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_r <= 1'h0;
        end else begin
            irq_r <= |(status_r & mask_r & gate);
        end
    end

endmodule

//--- demag_phase_core.sv
// Comparator edge detection, demagnetization phase tracking and mode preload.
`timescale 1ns/1ps
module demag_phase_core
    import motor_cfg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Motor side
    input wire logic cmp_raw,
    input wire logic commutate,
    // Configuration and events
    motor_cfg_if.core cfg
);

    logic cmp_s1_r;
    logic cmp_s2_r;
    logic cmp_d_r;
    logic rise;
    logic fall;
    logic zc_edge;
    logic demag_edge;
    logic demag_end;
    phase_type phase_r;
    logic zc_evt_r;
    logic demag_end_r;
    logic pre_active_r;

    // ------------------------------------------------------------
    // Comparator synchroniser and edges
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_s1_r <= 1'h0;
            cmp_s2_r <= 1'h0;
            cmp_d_r <= 1'h0;
        end else begin
            cmp_s1_r <= cmp_raw;
            cmp_s2_r <= cmp_s1_r;
            cmp_d_r <= cmp_s2_r;
        end
    end

    assign rise = cmp_s2_r & ~cmp_d_r;
    assign fall = ~cmp_s2_r & cmp_d_r;
    assign zc_edge = cfg.zc_pol ? rise : fall;
    // Demagnetization ends on the opposite comparator edge.
    assign demag_edge = cfg.zc_pol ? fall : rise;
    assign demag_end = (phase_r == PH_PRE) && !commutate
        && ((cfg.hw_en && demag_edge) || (cfg.sw_en && cfg.sw_demag_req));

    // ------------------------------------------------------------
    // Step phase: commutation to demag end, then to next commutation
    // ------------------------------------------------------------
    // step phase tracking
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= PH_POST;
        end else begin
            case (phase_r)
                PH_PRE: begin
                    if (demag_end) begin
                        phase_r <= PH_POST;
                    end
                end
                PH_POST: begin
                    if (commutate) begin
                        phase_r <= PH_PRE;
                    end
                end
                default: begin
                    phase_r <= PH_POST;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            zc_evt_r <= 1'h0;
            demag_end_r <= 1'h0;
        end else begin
            zc_evt_r <= (phase_r == PH_POST) && zc_edge;
            demag_end_r <= demag_end;
        end
    end

    // ------------------------------------------------------------
    // Preloaded pre-demag mode bit
    // ------------------------------------------------------------
    // preload transfer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_active_r <= 1'h0;
        end else if (cfg.direct || commutate) begin
            pre_active_r <= cfg.pre_mode_load;
        end
    end

    assign cfg.zc_evt = zc_evt_r;
    assign cfg.demag_end_evt = demag_end_r;
    assign cfg.before_demag = (phase_r == PH_PRE) && !cfg.sensor;
    assign cfg.pre_mode_active = pre_active_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_zc_edge_polarity: assert property (@(posedge core_clk) disable iff (!rst_b)
        zc_evt_r |-> ($past(cmp_s2_r) != $past(cmp_d_r))
            && ($past(cmp_s2_r) == $past(cfg.zc_pol)))
        else $error("zero crossing on wrong comparator edge");

    a_hw_demag_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        (demag_end_r && !$past(cfg.sw_demag_req)) |-> $past(cfg.hw_en))
        else $error("hardware demag event while disabled");

    a_sw_demag_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        (demag_end_r && !$past(cfg.hw_en)) |-> ($past(cfg.sw_en) && $past(cfg.sw_demag_req)))
        else $error("software demag event while disabled");

endmodule

//--- motor_ctrl_cfg_b.sv
// Motor configuration register B with Avalon-MM slave, phase core and interrupts.
//
// Contract
// - Eight-bit configuration register is read/write and resets to all zeros.
// - Bits 7:6 select one of four comparator thresholds, 0.2V up to 2.5V.
// - Edge polarity bit 0 detects falling zero crossings, 1 detects rising.
// - Hardware demagnetization events occur only while their enable bit is set.
// - Software demagnetization events occur only while their enable bit is set.
// - Bits 2:0 configure how PWM is applied during each commutation step.
// - Top mode bit passes a preload stage; lower two mode bits apply directly.
// - Top bit rules before demag end; lower bits rule until next commutation.
// - Without direct phase access, preloaded values become active at commutation.
// - Demag-end interrupt mask works only when hardware or software demag enabled.
// - Sensor mode disables the top mode bit, leaving only after-demag behaviour; here pwm_before_demag is held low but the bit still loads.
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module motor_ctrl_cfg_b
    import motor_cfg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Motor side
    input wire logic cmp_raw,
    input wire logic commutate,
    // Configuration outputs
    output logic [1:0] ref_threshold_sel,
    output logic [11:0] ref_threshold_mv,
    output logic zc_edge_polarity,
    output logic pwm_before_demag,
    output logic pre_demag_pwm_mode,
    output logic [1:0] post_demag_pwm_mode,
    // Events and interrupt
    output logic zc_event,
    output logic demag_end_event,
    output logic irq
);

    logic [7:0] motor_config_b_r;
    logic sensor_mode_sel_r;
    logic direct_access_r;
    logic sw_demag_req_r;
    logic ack_r;
    logic [31:0] readdata_r;
    logic [31:0] rd_nxt;
    logic accept;
    logic wr_cfg;
    logic wr_ctrl;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_gate;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq_r;
    logic hw_demag_enable;
    logic sw_demag_enable;
    logic cfg_pre;
    logic [1:0] wd_post;

    motor_cfg_if cfg_if ();

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // Every access is answered at the second edge after it is raised.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'h0;
        end else begin
            ack_r <= (read || write) && !ack_r;
        end
    end

    assign waitrequest = (read || write) && !ack_r;
    assign accept = ack_r && (read || write);
    assign wr_cfg = accept && write && (address == CFG_B_ADDR);
    assign wr_ctrl = accept && write && (address == CTRL_ADDR);

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    // full register store
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            motor_config_b_r <= CFG_B_RESET;
        end else if (wr_cfg) begin
            motor_config_b_r <= writedata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sensor_mode_sel_r <= 1'h0;
            direct_access_r <= 1'h0;
        end else if (wr_ctrl) begin
            sensor_mode_sel_r <= writedata[SENSOR_BIT];
            direct_access_r <= writedata[DIRECT_BIT];
        end
    end

    // Writing a one to the trigger bit requests one software demag event.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_demag_req_r <= 1'h0;
        end else begin
            sw_demag_req_r <= wr_ctrl && writedata[SWDM_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (address)
            CFG_B_ADDR: begin
                rd_nxt[7:0] = motor_config_b_r;
            end
            IRQ_STAT_ADDR: begin
                rd_nxt[IRQ_W-1:0] = irq_status;
            end
            IRQ_MASK_ADDR: begin
                rd_nxt[IRQ_W-1:0] = irq_mask;
            end
            CTRL_ADDR: begin
                rd_nxt[SENSOR_BIT] = sensor_mode_sel_r;
                rd_nxt[DIRECT_BIT] = direct_access_r;
                rd_nxt[PRE_ACT_BIT] = cfg_if.pre_mode_active;
                rd_nxt[PHASE_BIT] = cfg_if.before_demag;
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata_r <= 32'h0000_0000;
        end else if (read && !ack_r) begin
            readdata_r <= rd_nxt;
        end
    end

    assign readdata = readdata_r;

    // ------------------------------------------------------------
    // Field decode towards the phase core
    // ------------------------------------------------------------
    assign hw_demag_enable = motor_config_b_r[HW_BIT];
    assign sw_demag_enable = motor_config_b_r[SW_BIT];
    assign cfg_pre = motor_config_b_r[PRE_BIT];
    assign wd_post = writedata[POST_LSB+1:POST_LSB];

    assign cfg_if.vref = motor_config_b_r[VR_LSB+1:VR_LSB];
    assign cfg_if.zc_pol = motor_config_b_r[POL_BIT];
    assign cfg_if.hw_en = hw_demag_enable;
    assign cfg_if.sw_en = sw_demag_enable;
    assign cfg_if.pre_mode_load = cfg_pre;
    assign cfg_if.sensor = sensor_mode_sel_r;
    assign cfg_if.direct = direct_access_r;
    assign cfg_if.sw_demag_req = sw_demag_req_r;

    demag_phase_core u_core (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cmp_raw(cmp_raw),
        .commutate(commutate),
        .cfg(cfg_if.core)
    );

    // ------------------------------------------------------------
    // Threshold selection
    // ------------------------------------------------------------
    // threshold code map
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_threshold_mv <= VREF_MV_0;
        end else begin
            case (cfg_if.vref)
                2'h0: ref_threshold_mv <= VREF_MV_0;
                2'h1: ref_threshold_mv <= VREF_MV_1;
                2'h2: ref_threshold_mv <= VREF_MV_2;
                default: ref_threshold_mv <= VREF_MV_3;
            endcase
        end
    end

    assign ref_threshold_sel = cfg_if.vref;
    assign zc_edge_polarity = cfg_if.zc_pol;
    assign post_demag_pwm_mode = motor_config_b_r[POST_LSB+1:POST_LSB];
    assign pre_demag_pwm_mode = cfg_if.pre_mode_active;
    assign pwm_before_demag = cfg_if.before_demag;
    assign zc_event = cfg_if.zc_evt;
    assign demag_end_event = cfg_if.demag_end_evt;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_evt[IRQ_COMM] = commutate;
    assign irq_evt[IRQ_DEMAG] = cfg_if.demag_end_evt;
    assign irq_evt[IRQ_ZC] = cfg_if.zc_evt;
    assign irq_gate[IRQ_COMM] = 1'h1;
    assign irq_gate[IRQ_DEMAG] = hw_demag_enable || sw_demag_enable;
    assign irq_gate[IRQ_ZC] = 1'h1;

    irq_sticky u_irq (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .evt(irq_evt),
        .clr_we(accept && write && (address == IRQ_STAT_ADDR)),
        .mask_we(accept && write && (address == IRQ_MASK_ADDR)),
        .wdata(writedata[IRQ_W-1:0]),
        .gate(irq_gate),
        .status_r(irq_status),
        .mask_r(irq_mask),
        .irq_r(irq_r)
    );

    assign irq = irq_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_cfg_write_store: assert property (
        wr_cfg |=> motor_config_b_r == $past(writedata[7:0]))
        else $error("configuration write not stored");

    a_vref_low_code: assert property (
        $past(ref_threshold_sel) == 2'h0 |-> ref_threshold_mv == VREF_MV_0)
        else $error("lowest threshold code gives wrong level");

    a_vref_high_code: assert property (
        $past(ref_threshold_sel) == 2'h3 |-> ref_threshold_mv == VREF_MV_3)
        else $error("highest threshold code gives wrong level");

    a_post_mode_direct: assert property (
        wr_cfg |=> post_demag_pwm_mode == $past(wd_post))
        else $error("lower mode bits not applied at once");

    a_pre_mode_hold: assert property (
        (!commutate && !direct_access_r) |=> $stable(pre_demag_pwm_mode))
        else $error("top mode bit changed outside commutation");

    a_pre_mode_load: assert property (
        (commutate && !direct_access_r) |=> pre_demag_pwm_mode == $past(cfg_pre))
        else $error("top mode bit not loaded at commutation");

    a_step_phase_start: assert property (
        (commutate && !sensor_mode_sel_r) ##1 !sensor_mode_sel_r |-> pwm_before_demag)
        else $error("commutation did not open the pre-demag phase");

    a_step_phase_end: assert property (
        demag_end_event |-> !pwm_before_demag)
        else $error("phase not closed at demag end");

    a_sensor_post_only: assert property (
        sensor_mode_sel_r |-> !pwm_before_demag)
        else $error("pre-demag behaviour active in sensor mode");

    a_demag_irq_gate: assert property (
        (irq_mask == 3'h2 && !hw_demag_enable && !sw_demag_enable) |=> !irq)
        else $error("demag interrupt raised with demag disabled");

    a_read_wait: assert property (
        (read && !ack_r) |-> waitrequest ##1 !waitrequest)
        else $error("read answer not at second edge");

    a_write_wait: assert property (
        (write && !ack_r) |-> waitrequest ##1 !waitrequest)
        else $error("write answer not at second edge");

    a_vref_code_one: assert property (
        $past(ref_threshold_sel) == 2'h1 |-> ref_threshold_mv == VREF_MV_1)
        else $error("second threshold code gives wrong level");

    a_vref_code_two: assert property (
        $past(ref_threshold_sel) == 2'h2 |-> ref_threshold_mv == VREF_MV_2)
        else $error("third threshold code gives wrong level");

    // The request follows the gated, masked status with one cycle of lag.
    a_irq_level_out: assert property (
        (|(irq_status & irq_mask & irq_gate)) |=> irq)
        else $error("unmasked interrupt not raised");

    c_cfg_write: cover property (wr_cfg);
    c_sw_demag: cover property (sw_demag_req_r && pwm_before_demag);
    c_demag_end: cover property (commutate ##[1:20] demag_end_event);
    c_zero_cross: cover property (zc_event);
    c_irq_raise: cover property (!irq ##1 irq);

endmodule

//--- motor_stage_model.sv
// Power stage and back-EMF sense model driving the comparator and commutation pins.
`timescale 1ns/1ps
module motor_stage_model (
    // Clock
    input wire logic core_clk,
    // Motor side
    output logic cmp_raw,
    output logic commutate
);
    initial begin
        cmp_raw = 1'b0;
        commutate = 1'b0;
    end

    // The comparator output is always valid, so it simply holds its level.
    task set_cmp(input logic v);
        @(posedge core_clk);
        cmp_raw <= v;
    endtask

    // Commutation is a single-cycle pulse.
    task pulse;
        @(posedge core_clk);
        commutate <= 1'b1;
        @(posedge core_clk);
        commutate <= 1'b0;
    endtask
endmodule

//--- motor_ctrl_cfg_b_tb.sv
// Self-checking testbench of the motor configuration register block.
`timescale 1ns/1ps
module motor_ctrl_cfg_b_tb;
    import motor_cfg_pkg::*;
    logic core_clk, rst_b, read, write, cmp_raw, commutate, zc_event, demag_end_event, irq;
    logic [3:0] address;
    logic [31:0] writedata, readdata, q;
    logic waitrequest, zc_edge_polarity, pwm_before_demag, pre_demag_pwm_mode;
    logic [1:0] ref_threshold_sel, post_demag_pwm_mode;
    logic [11:0] ref_threshold_mv;
    int fails, n_compared, cyc, n_zc, n_dm;

    motor_ctrl_cfg_b i_dut (.core_clk(core_clk), .rst_b(rst_b), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .cmp_raw(cmp_raw), .commutate(commutate),
        .ref_threshold_sel(ref_threshold_sel), .ref_threshold_mv(ref_threshold_mv),
        .zc_edge_polarity(zc_edge_polarity), .pwm_before_demag(pwm_before_demag),
        .pre_demag_pwm_mode(pre_demag_pwm_mode), .post_demag_pwm_mode(post_demag_pwm_mode),
        .zc_event(zc_event), .demag_end_event(demag_end_event), .irq(irq));
    motor_stage_model i_stage (.core_clk(core_clk), .cmp_raw(cmp_raw), .commutate(commutate));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out;
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (zc_event === 1'b1) begin
            n_zc++;
        end
        if (demag_end_event === 1'b1) begin
            n_dm++;
        end
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    // Holds the request until a rising edge samples waitrequest low.
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask

    task comm;
        i_stage.pulse();
        repeat (3) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd("cfg", CFG_B_ADDR, 32'h0);
        rd("stat", IRQ_STAT_ADDR, 32'h0);
        rd("mask", IRQ_MASK_ADDR, 32'h0);
        chk("mv", ref_threshold_mv, 32'h0C8);
    endtask

    task t_rw;
        wr(CFG_B_ADDR, 32'hFF);
        rd("cfg", CFG_B_ADDR, 32'hFF);
        chk("pre", pre_demag_pwm_mode, 32'h0);
        wr(CFG_B_ADDR, 32'h5A);
        wr(4'h2, 32'hFF);
        rd("cfg", CFG_B_ADDR, 32'h5A);
        rd("unmapped", 4'h2, 32'h0);
        chk("post", post_demag_pwm_mode, 32'h2);
    endtask

    task t_vref;
        logic [11:0] mv [4];
        mv = '{12'h0C8, 12'h258, 12'h4B0, 12'h9C4};
        for (int i = 0; i < 4; i++) begin
            wr(CFG_B_ADDR, 32'(i) << 6);
            repeat (2) @(posedge core_clk);
            chk("sel", ref_threshold_sel, 32'(i));
            chk("mv", ref_threshold_mv, mv[i]);
        end
    endtask

    task t_preload;
        wr(CFG_B_ADDR, 32'h04);
        chk("pre", pre_demag_pwm_mode, 32'h0);
        comm();
        chk("pre", pre_demag_pwm_mode, 32'h1);
        wr(CFG_B_ADDR, 32'h0);
        chk("pre", pre_demag_pwm_mode, 32'h1);
        wr(CTRL_ADDR, 32'h1 << DIRECT_BIT);
        repeat (2) @(posedge core_clk);
        chk("pre", pre_demag_pwm_mode, 32'h0);
        wr(CTRL_ADDR, 32'h0);
    endtask

    task t_demag(input logic pol, input logic hw);
        int z0, d0;
        wr(CFG_B_ADDR, {26'h0, pol, hw, 4'h0});
        i_stage.set_cmp(pol);
        repeat (8) @(posedge core_clk);
        wr(IRQ_STAT_ADDR, 32'h7);
        z0 = n_zc;
        d0 = n_dm;
        comm();
        chk("before", pwm_before_demag, 32'h1);
        i_stage.set_cmp(!pol);
        repeat (8) @(posedge core_clk);
        chk("before", pwm_before_demag, 32'(!hw));
        rd("stat", IRQ_STAT_ADDR, {30'h0, hw, 1'b1});
        i_stage.set_cmp(pol);
        repeat (8) @(posedge core_clk);
        rd("stat", IRQ_STAT_ADDR, hw ? 32'h7 : 32'h1);
        chk("pol", zc_edge_polarity, 32'(pol));
        chk("zc_n", n_zc - z0, 32'(hw));
        chk("dm_n", n_dm - d0, 32'(hw));
    endtask

    task t_sw(input logic en);
        int d0;
        wr(CFG_B_ADDR, {28'h0, en, 3'h0});
        wr(IRQ_STAT_ADDR, 32'h7);
        comm();
        d0 = n_dm;
        wr(CTRL_ADDR, 32'h1 << SWDM_BIT);
        repeat (4) @(posedge core_clk);
        chk("before", pwm_before_demag, 32'(!en));
        rd("stat", IRQ_STAT_ADDR, {30'h0, en, 1'b1});
        chk("dm_n", n_dm - d0, 32'(en));
    endtask

    task t_irq;
        t_sw(1'b1);
        wr(IRQ_MASK_ADDR, 32'h2);
        rd("mask", IRQ_MASK_ADDR, 32'h2);
        repeat (3) @(posedge core_clk);
        chk("irq", irq, 32'h1);
        wr(CFG_B_ADDR, 32'h0);
        repeat (3) @(posedge core_clk);
        chk("irq", irq, 32'h0);
        wr(CFG_B_ADDR, 32'h08);
        repeat (3) @(posedge core_clk);
        chk("irq", irq, 32'h1);
        wr(IRQ_STAT_ADDR, 32'h2);
        repeat (3) @(posedge core_clk);
        chk("irq", irq, 32'h0);
    endtask

    task t_sensor;
        wr(CTRL_ADDR, 32'h1 << SENSOR_BIT);
        wr(CFG_B_ADDR, 32'h04);
        comm();
        chk("before", pwm_before_demag, 32'h0);
        rd("ctrl", CTRL_ADDR, 32'h9);
        wr(CTRL_ADDR, 32'h0);
    endtask

    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_rw();
        t_vref();
        t_preload();
        t_demag(1'b0, 1'b1);
        t_demag(1'b1, 1'b1);
        t_demag(1'b1, 1'b0);
        t_sw(1'b1);
        t_sw(1'b0);
        t_irq();
        t_sensor();
        close_out();
    end
endmodule
